//--- design/npic_ctrl.sv
// module: nested priority interrupt controller top
// Behaviour
// - current level lives in condition-code bits 5 (high) and 3 (low)
// - codes: 10 level0, 01 level1, 00 level2, 11 level3 masks all maskables
// - on maskable entry current level loads the serviced vector's stored pair
// - pin interrupt, trap and reset preempt level 3; maskables do not
// - vectors below trap own pairs 0..13 in four priority registers
// - writing pattern 10 into a pair leaves that pair unchanged
// - priority registers reset to ones; upper half of fourth reads ones
// - pin interrupt, trap and reset entry set level 3
// - pin interrupt pair is stored but ignored by arbitration
// - reprioritised vector re-enters only if pending and now higher
// - enable, halt, wait load 10; disable, trap 11; return, pop restore
// - branch flags: one when level equals 11, one otherwise
// - instruction level changes persist until return or next such op
// - reset, trap, then sources 0..13 down to lowest vector; 6 unused
// - halt wake: pin, time base, ext lines, spi slave, timer ext clock
// - active halt wakes only on reset or time base
// - modes per pair of lines (0-1, 2-3); rising with high level only on lines 0 and 2
// - changing sense or polarity bits clears pending ext requests
// - four external lines, sensed in pairs sharing a mode
// - highest software priority wins; ties by fixed hardware order
// - maskable served only if enabled and above current level
// - edge requests latch and clear on entry to their routine
// - sense codes 00 fall+low, 01 rise, 10 fall, 11 both; invertible
module npic_ctrl
	import npic_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic instrBoundary,
	input wire logic opStrobe,
	input wire npic_op_t instrOp,
	input wire logic [7:0] stackCc,
	input wire logic tliPin,
	input wire logic [3:0] extLine,
	input wire logic timebaseReq,
	input wire logic [13:7] periphReq,
	input wire logic haltMode,
	input wire logic activeHaltMode,
	input wire logic spiSlaveMode,
	input wire logic artExtClkMode,
	output logic irqPending,
	output logic entryStrobe,
	output logic [3:0] entryVector,
	output logic [1:0] entryPair,
	output logic [15:0] entryAddr,
	output logic [7:0] savedCc,
	output logic [7:0] ccOut,
	output logic branchIfMasked,
	output logic branchIfUnmasked,
	output logic wakeReq
);
	logic [7:0] cc_ff;
	logic [7:0] nxt_cc;
	logic [7:0] vp_ff [4];
	logic [7:0] nxt_vp [4];
	logic [7:0] ext_ff;
	logic [7:0] nxt_ext;
	logic tliPrev_ff;
	logic tliPend_ff;
	logic [7:0] regRdData_ff;
	logic entryStrobe_ff;
	logic [3:0] entryVector_ff;
	logic [1:0] entryPair_ff;
	logic [15:0] entryAddr_ff;
	logic [7:0] savedCc_ff;
	logic wakeReq_ff;
	logic [1:0] curPair;
	logic [31:0] vpFlat;
	logic [13:0] reqVec;
	logic [13:0] wakeMask;
	logic [13:0] haltMask;
	logic [3:0] extReq;
	logic [3:0] extPend;
	logic [4:0] pick;
	logic [3:0] pickIdx;
	logic [1:0] pickPair;
	logic trapNow;
	logic takeIrq;
	logic take;
	logic [3:0] takeVec;
	logic [1:0] takePair;
	logic [15:0] takeAddr;
	logic extWrite;
	logic senseChanged;
	logic levelIs3;
	logic tliEdge;
	logic [7:0] rdMux;

	// level code to rank: 10 lowest, 01, 00, 11 highest
	function automatic logic [2:0] levelRank(input logic [1:0] pair);
		unique case (pair)
			LVL0: levelRank = 3'd0;
			LVL1: levelRank = 3'd1;
			LVL2: levelRank = 3'd2;
			LVL3: levelRank = 3'd3;
		endcase
	endfunction

	// scan from lowest hardware priority so ties go to lower index
	function automatic logic [4:0] pickVector(input logic [13:0] req,
		input logic [31:0] pairs, input logic [1:0] cur);
		logic [4:0] best;
		logic [2:0] bestRank;
		logic [2:0] r;
		best = 5'h00;
		bestRank = 3'd0;
		r = 3'd0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			// pin interrupt ranks above level 3, its pair is ignored
			r = (i == 0) ? 3'd4 : levelRank(pairs[2 * i +: 2]);
			if (req[i] && r > levelRank(cur) && r >= bestRank) begin
				best = {1'b1, 4'(i)};
				bestRank = r;
			end
		end
		pickVector = best;
	endfunction

	// pattern 10 in any written pair keeps the stored pair
	function automatic logic [7:0] mergePairs(input logic [7:0] old, input logic [7:0] wd);
		logic [7:0] res;
		res = wd;
		for (int j = 0; j < 4; j++) begin
			if (wd[2 * j +: 2] == LVL0) begin
				res[2 * j +: 2] = old[2 * j +: 2];
			end
		end
		mergePairs = res;
	endfunction

	assign curPair = {cc_ff[CC_HI_POS], cc_ff[CC_LO_POS]};
	assign levelIs3 = (curPair == LVL3);
	assign vpFlat = {vp_ff[3], vp_ff[2], vp_ff[1], vp_ff[0]};

	// pin interrupt edge detector; the enable gates it at the latch
	assign tliEdge = ext_ff[EXT_TLI_SENSE_POS] ? (tliPin & ~tliPrev_ff) : (~tliPin & tliPrev_ff);

	// request vector in fixed hardware order, slot 6 unused
	assign reqVec = {periphReq, 1'b0, extReq, timebaseReq, tliPend_ff};

	// halt gating: only wake-capable sources may be served first
	assign wakeMask = WAKE_ALWAYS | (14'(spiSlaveMode) << SPI_IDX) |
		(14'(artExtClkMode) << ART_IDX);
	assign haltMask = activeHaltMode ? (14'h0001 << TB_IDX) :
		(haltMode ? wakeMask : 14'h3fff);

	// arbitration; a reprioritised vector competes against the level it runs at
	assign pick = pickVector(reqVec & haltMask, vpFlat, curPair);
	assign pickIdx = pick[3:0];
	assign pickPair = vpFlat[{pickIdx, 1'b0} +: 2];
	assign trapNow = opStrobe && (instrOp == OP_TRAP);
	assign takeIrq = instrBoundary && pick[4] && !trapNow;
	assign take = trapNow | takeIrq;
	assign takeVec = trapNow ? VEC_TRAP : pickIdx;
	assign takePair = (trapNow || pickIdx == VEC_TLI) ? LVL3 : pickPair;
	assign takeAddr = trapNow ? ADDR_TRAP : 16'(ADDR_SRC0 - {11'h000, pickIdx, 1'b0});

	// condition-code next value; entry beats an instruction load
	always_comb begin
		nxt_cc = cc_ff;
		if (take) begin
			nxt_cc[CC_HI_POS] = takePair[1];
			nxt_cc[CC_LO_POS] = takePair[0];
		end else if (opStrobe) begin
			unique case (instrOp)
				OP_RIM, OP_HALT, OP_WFI: begin
					nxt_cc[CC_HI_POS] = LVL0[1];
					nxt_cc[CC_LO_POS] = LVL0[0];
				end
				OP_SIM: begin
					nxt_cc[CC_HI_POS] = LVL3[1];
					nxt_cc[CC_LO_POS] = LVL3[0];
				end
				OP_RETURN_FROM_ISR_INSTR, OP_POPCC: nxt_cc = stackCc;
				OP_NONE, OP_TRAP: nxt_cc = cc_ff;
				default: nxt_cc = cc_ff;
			endcase
		end else if (regWrEn && regAddr == OFF_CC) begin
			nxt_cc = regWrData;
		end
	end

	// priority register writes
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			nxt_vp[k] = vp_ff[k];
			if (regWrEn && regAddr == OFF_VP0 + 8'(k)) begin
				nxt_vp[k] = mergePairs(vp_ff[k], regWrData);
			end
		end
		nxt_vp[3][7:4] = VP3_RO_ONES;
	end

	// sense bits follow the level-3 discipline; tli sense locked while enabled
	assign extWrite = regWrEn && (regAddr == OFF_EXT);
	assign nxt_ext[7:2] = (extWrite && levelIs3) ? regWrData[7:2] : ext_ff[7:2];
	assign nxt_ext[EXT_TLI_SENSE_POS] = (extWrite && !ext_ff[EXT_TLI_EN_POS]) ?
		regWrData[EXT_TLI_SENSE_POS] : ext_ff[EXT_TLI_SENSE_POS];
	assign nxt_ext[EXT_TLI_EN_POS] = extWrite ? regWrData[EXT_TLI_EN_POS] : ext_ff[EXT_TLI_EN_POS];
	assign senseChanged = (nxt_ext[7:2] != ext_ff[7:2]);

	// four sense slices; lines 0 and 2 may invert
	for (genvar g = 0; g < 4; g++) begin : g_line
		npic_sense_if sb ();
		assign sb.senseSel = (g < 2) ? ext_ff[EXT_SEL_A_POS +: 2] : ext_ff[EXT_SEL_B_POS +: 2];
		assign sb.invert = (g < 2) ? ext_ff[EXT_INV_A_POS] : ext_ff[EXT_INV_B_POS];
		assign sb.pinLevel = extLine[g];
		assign sb.clearPending = senseChanged | (take && takeVec == 4'(VEC_EXT0 + g));
		npic_ext_sense #(.HAS_INVERT(g % 2 == 0)) u_sense (
			.clock(clock),
			.arst_n(arst_n),
			.sense(sb.line)
		);
		assign extReq[g] = sb.request;
		assign extPend[g] = sb.pending;
	end

	// register read decode, unmapped reads zero
	assign rdMux = (regAddr <= OFF_VP3) ? vp_ff[regAddr[1:0]] :
		(regAddr == OFF_EXT) ? ext_ff :
		(regAddr == OFF_CC) ? cc_ff : 8'h00;

	// condition code and priority registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cc_ff <= RST_CC;
			vp_ff <= '{RST_VP, RST_VP, RST_VP, RST_VP};
			ext_ff <= RST_EXT;
		end else begin
			cc_ff <= nxt_cc;
			vp_ff <= nxt_vp;
			ext_ff <= nxt_ext;
		end
	end

	// pin interrupt latch: new edge wins over clear on entry
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tliPrev_ff <= 1'b1;
			tliPend_ff <= 1'b0;
		end else begin
			tliPrev_ff <= tliPin;
			tliPend_ff <= (tliEdge & ext_ff[EXT_TLI_EN_POS]) |
				(tliPend_ff & ~(takeIrq && pickIdx == VEC_TLI));
		end
	end

	// entry hand-off to the core and read data
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			entryStrobe_ff <= 1'b0;
			entryVector_ff <= 4'h0;
			entryPair_ff <= 2'b00;
			entryAddr_ff <= 16'h0000;
			savedCc_ff <= 8'h00;
			regRdData_ff <= 8'h00;
			wakeReq_ff <= 1'b0;
		end else begin
			entryStrobe_ff <= take;
			entryVector_ff <= take ? takeVec : entryVector_ff;
			entryPair_ff <= take ? takePair : entryPair_ff;
			entryAddr_ff <= take ? takeAddr : entryAddr_ff;
			savedCc_ff <= take ? cc_ff : savedCc_ff;
			regRdData_ff <= regRdEn ? rdMux : 8'h00;
			wakeReq_ff <= (haltMode | activeHaltMode) && |(reqVec & haltMask);
		end
	end

	assign regRdData = regRdData_ff;
	assign irqPending = pick[4];
	assign entryStrobe = entryStrobe_ff;
	assign entryVector = entryVector_ff;
	assign entryPair = entryPair_ff;
	assign entryAddr = entryAddr_ff;
	assign savedCc = savedCc_ff;
	assign ccOut = cc_ff;
	assign branchIfMasked = levelIs3;
	assign branchIfUnmasked = !levelIs3;
	assign wakeReq = wakeReq_ff;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_maskableTake;
		instrBoundary && !trapNow && pick[4] && pickIdx != VEC_TLI;
	endsequence
	sequence s_rimDone;
		opStrobe && instrOp == OP_RIM && !take;
	endsequence

	property p_entryLoadsPair;
		s_maskableTake |=> entryStrobe && curPair == $past(pickPair) &&
			entryVector == $past(pickIdx);
	endproperty
	a_entryLoadsPair: assert property (p_entryLoadsPair) else $error("entry pair not loaded");

	property p_level3Blocks;
		instrBoundary && levelIs3 && !reqVec[0] && !trapNow |=> !entryStrobe;
	endproperty
	a_level3Blocks: assert property (p_level3Blocks) else $error("maskable taken at level 3");

	property p_topEntryLevel3;
		entryStrobe && (entryVector == VEC_TLI || entryVector == VEC_TRAP) |-> levelIs3;
	endproperty
	a_topEntryLevel3: assert property (p_topEntryLevel3) else $error("top entry not level 3");

	property p_level0Ignored;
		regWrEn && regAddr == OFF_VP0 && regWrData[1:0] == LVL0 |=>
			vp_ff[0][1:0] == $past(vp_ff[0][1:0]);
	endproperty
	a_level0Ignored: assert property (p_level0Ignored) else $error("level 0 pair stored");

	property p_vp3UpperOnes;
		regRdEn && regAddr == OFF_VP3 |=> regRdData[7:4] == VP3_RO_ONES;
	endproperty
	a_vp3UpperOnes: assert property (p_vp3UpperOnes) else $error("upper bits not ones");

	property p_rimLevel0;
		s_rimDone |=> curPair == LVL0 && branchIfUnmasked && !branchIfMasked;
	endproperty
	a_rimLevel0: assert property (p_rimLevel0) else $error("enable did not load 10");

	property p_simMasks;
		opStrobe && instrOp == OP_SIM && !take |=> branchIfMasked && !branchIfUnmasked;
	endproperty
	a_simMasks: assert property (p_simMasks) else $error("disable did not mask");

	property p_activeHaltWake;
		activeHaltMode && !timebaseReq |=> !wakeReq;
	endproperty
	a_activeHaltWake: assert property (p_activeHaltWake) else $error("bad active halt wake");

	property p_spiWake;
		haltMode && !activeHaltMode && !spiSlaveMode && reqVec == 14'h0080 |=> !wakeReq;
	endproperty
	a_spiWake: assert property (p_spiWake) else $error("spi woke outside slave mode");
endmodule

//--- design/npic_ext_sense.sv
// module: edge/level sensing and pending latch of one external line
module npic_ext_sense
	import npic_pkg::*;
#(
	parameter bit HAS_INVERT = 1'b0
) (
	input wire logic clock,
	input wire logic arst_n,
	npic_sense_if.line sense
);
	logic prevPin_ff;
	logic pending_ff;
	logic invEff;
	logic rise;
	logic fall;
	logic edgeHit;
	logic levelHit;
	logic nxt_pending;

	// inversion only exists on the even lines, 0 and 2
	assign invEff = HAS_INVERT & sense.invert;
	assign rise = sense.pinLevel & ~prevPin_ff;
	assign fall = ~sense.pinLevel & prevPin_ff;
	// 00 fall+low, 01 rise, 10 fall, 11 both; invert swaps edges
	assign edgeHit = (sense.senseSel == SENSE_BOTH) ? (rise | fall) :
		(sense.senseSel == SENSE_RISE) ? (invEff ? fall : rise) :
		(invEff ? rise : fall);
	assign levelHit = (sense.senseSel == SENSE_FALL_LOW) &
		(invEff ? sense.pinLevel : ~sense.pinLevel);
	// new edge beats a clear in the same cycle
	assign nxt_pending = edgeHit | (pending_ff & ~sense.clearPending);
	assign sense.request = pending_ff | levelHit;
	assign sense.pending = pending_ff;

	// idle-high assumption avoids a false rise at release
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prevPin_ff <= 1'b1;
			pending_ff <= 1'b0;
		end else begin
			prevPin_ff <= sense.pinLevel;
			pending_ff <= nxt_pending;
		end
	end
endmodule

//--- design/npic_pkg.sv
// package: constants and types of the nested priority interrupt controller
package npic_pkg;
	localparam int NUM_SRC = 14;
	// register offsets
	localparam logic [7:0] OFF_VP0 = 8'h00;
	localparam logic [7:0] OFF_VP3 = 8'h03;
	localparam logic [7:0] OFF_EXT = 8'h04;
	localparam logic [7:0] OFF_CC = 8'h05;
	// reset values
	localparam logic [7:0] RST_VP = 8'hff;
	localparam logic [7:0] RST_EXT = 8'h00;
	localparam logic [7:0] RST_CC = 8'hea;
	localparam logic [3:0] VP3_RO_ONES = 4'hf;
	// field positions
	localparam int CC_HI_POS = 5;
	localparam int CC_LO_POS = 3;
	localparam int EXT_SEL_B_POS = 6;
	localparam int EXT_INV_B_POS = 5;
	localparam int EXT_SEL_A_POS = 3;
	localparam int EXT_INV_A_POS = 2;
	localparam int EXT_TLI_SENSE_POS = 1;
	localparam int EXT_TLI_EN_POS = 0;
	// priority level codes
	localparam logic [1:0] LVL0 = 2'b10;
	localparam logic [1:0] LVL1 = 2'b01;
	localparam logic [1:0] LVL2 = 2'b00;
	localparam logic [1:0] LVL3 = 2'b11;
	// external line sense codes
	localparam logic [1:0] SENSE_FALL_LOW = 2'b00;
	localparam logic [1:0] SENSE_RISE = 2'b01;
	localparam logic [1:0] SENSE_BOTH = 2'b11;
	// vector indices and addresses
	localparam logic [3:0] VEC_TLI = 4'h0;
	localparam logic [3:0] VEC_EXT0 = 4'h2;
	localparam logic [3:0] VEC_TRAP = 4'he;
	localparam logic [15:0] ADDR_TRAP = 16'hfffc;
	localparam logic [15:0] ADDR_SRC0 = 16'hfffa;
	// sources that always wake from halt: pin, time base, ext lines
	localparam logic [13:0] WAKE_ALWAYS = 14'h003f;
	localparam int SPI_IDX = 7;
	localparam int ART_IDX = 13;
	localparam int TB_IDX = 1;
	// instruction events from the sequencer
	typedef enum logic [7:0] {
		OP_NONE = 8'h01,
		OP_RIM = 8'h02,
		OP_SIM = 8'h04,
		OP_HALT = 8'h08,
		OP_WFI = 8'h10,
		OP_RETURN_FROM_ISR_INSTR = 8'h20,
		OP_POPCC = 8'h40,
		OP_TRAP = 8'h80
	} npic_op_t;
endpackage

//--- design/npic_sense_if.sv
// interface: one external line between controller and its sense logic
interface npic_sense_if;
	logic [1:0] senseSel;
	logic invert;
	logic pinLevel;
	logic clearPending;
	logic request;
	logic pending;
	modport ctrl (output senseSel, invert, pinLevel, clearPending, input request, pending);
	modport line (input senseSel, invert, pinLevel, clearPending, output request, pending);
endinterface

//--- tb/npic_core_model.sv
// model: instruction sequencer and stack of the processor core
module npic_core_model
	import npic_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic entryStrobe,
	input wire logic [7:0] savedCc,
	output logic instrBoundary,
	output logic opStrobe,
	output npic_op_t instrOp,
	output logic [7:0] stackCc
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] stack[$];
	initial begin
		instrBoundary = 1'b0;
		opStrobe = 1'b0;
		instrOp = OP_NONE;
		stackCc = 8'h00;
	end
	// push on the falling edge so a pop at the next rising edge sees it
	always @(negedge clock) begin
		if (entryStrobe && arst_n)
			stack.push_back(savedCc);
	end
	// one instruction boundary, one cycle wide
	task automatic boundary();
		@(posedge clock);
		instrBoundary <= 1'b1;
		@(posedge clock);
		instrBoundary <= 1'b0;
	endtask
	// one completing instruction; return pops what entry pushed
	task automatic issue(input npic_op_t o, input logic [7:0] cc);
		@(posedge clock);
		opStrobe <= 1'b1;
		instrOp <= o;
		if (o == OP_RETURN_FROM_ISR_INSTR && stack.size() > 0)
			stackCc <= stack.pop_back();
		else
			stackCc <= cc;
		@(posedge clock);
		opStrobe <= 1'b0;
		instrOp <= OP_NONE;
		stackCc <= ~stackCc; // released bus shows no stale value
	endtask
endmodule

//--- tb/npic_ctrl_tb_top.sv
// testbench: directed scenarios for the nested priority interrupt controller
module npic_ctrl_tb_top
	import npic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, arst_n, regWrEn, regRdEn, instrBoundary, opStrobe, tliPin, timebaseReq;
	logic haltMode, activeHaltMode, spiSlaveMode, artExtClkMode, irqPending, entryStrobe;
	logic branchIfMasked, branchIfUnmasked, wakeReq;
	logic [7:0] regAddr, regWrData, regRdData, stackCc, savedCc, ccOut;
	logic [3:0] extLine, entryVector;
	logic [13:7] periphReq;
	logic [1:0] entryPair;
	logic [15:0] entryAddr;
	npic_op_t instrOp;
	int err_total = 0;
	int num_checks = 0;
	npic_ctrl DUT (.clock, .arst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
		.instrBoundary, .opStrobe, .instrOp, .stackCc, .tliPin, .extLine, .timebaseReq,
		.periphReq, .haltMode, .activeHaltMode, .spiSlaveMode, .artExtClkMode, .irqPending,
		.entryStrobe, .entryVector, .entryPair, .entryAddr, .savedCc, .ccOut, .branchIfMasked,
		.branchIfUnmasked, .wakeReq);
	npic_core_model CORE (.clock, .arst_n, .entryStrobe, .savedCc, .instrBoundary, .opStrobe,
		.instrOp, .stackCc);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrEn <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRdEn <= 1'b0;
		@(negedge clock);
		chk("regRdData", {8'h00, exp}, {8'h00, regRdData});
	endtask
	task automatic lvl(input logic [1:0] e);
		chk("level", {14'h0, e}, {14'h0, ccOut[5], ccOut[3]});
		chk("branchIfMasked", {15'h0, e == LVL3}, {15'h0, branchIfMasked});
		chk("branchIfUnmasked", {15'h0, e != LVL3}, {15'h0, branchIfUnmasked});
		// hand back on a rising edge so the next drive lands there
		@(posedge clock);
	endtask
	task automatic op(input npic_op_t o, input logic [7:0] cc, input logic [1:0] e);
		CORE.issue(o, cc);
		@(negedge clock);
		lvl(e);
	endtask
	task automatic ent(input logic [3:0] v, input logic [1:0] p, input logic [15:0] a);
		@(negedge clock);
		chk("entryStrobe", 16'h0001, {15'h0, entryStrobe});
		chk("entryVector", {12'h0, v}, {12'h0, entryVector});
		chk("entryPair", {14'h0, p}, {14'h0, entryPair});
		chk("entryAddr", a, entryAddr);
		lvl(p);
	endtask
	task automatic pend(input logic e);
		@(negedge clock);
		chk("irqPending", {15'h0, e}, {15'h0, irqPending});
		@(posedge clock);
	endtask
	task automatic t_reset();
		rd(OFF_VP0, RST_VP);
		rd(8'h01, RST_VP);
		rd(8'h02, RST_VP);
		rd(OFF_VP3, RST_VP);
		rd(OFF_EXT, RST_EXT);
		rd(OFF_CC, RST_CC);
		rd(8'h3c, 8'h00);
		lvl(LVL3);
		$display("test reset done");
	endtask
	task automatic t_regs();
		wr(OFF_VP0, 8'hcf);
		wr(OFF_VP0, 8'h64);
		rd(OFF_VP0, 8'h44);
		// pattern 10 in three pairs, pin interrupt pair among them
		wr(OFF_VP0, 8'hae);
		rd(OFF_VP0, 8'h4c);
		wr(OFF_VP3, 8'h00);
		rd(OFF_VP3, 8'hf0);
		wr(OFF_VP0, 8'hdf);
		rd(OFF_VP0, 8'hdf);
		$display("test regs done");
	endtask
	task automatic t_instr();
		op(OP_RIM, 8'h00, LVL0);
		op(OP_SIM, 8'h00, LVL3);
		op(OP_WFI, 8'h00, LVL0);
		op(OP_SIM, 8'h00, LVL3);
		op(OP_HALT, 8'h00, LVL0);
		op(OP_POPCC, 8'h08, LVL1);
		op(OP_NONE, 8'hff, LVL1);
		op(OP_SIM, 8'h00, LVL3);
		$display("test instr done");
	endtask
	task automatic t_entry();
		wr(OFF_EXT, 8'h10);
		op(OP_RIM, 8'h00, LVL0);
		extLine <= 4'he;
		cyc(2);
		CORE.boundary();
		ent(VEC_EXT0, LVL1, 16'hfff6);
		// condition code before entry: level 0 loaded on 28h by enable
		chk("savedCc", 16'h0020, {8'h00, savedCc});
		extLine <= 4'hf;
		CORE.boundary();
		@(negedge clock);
		chk("entryStrobe", 16'h0000, {15'h0, entryStrobe});
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL0);
		pend(1'b0);
		$display("test entry done");
	endtask
	task automatic t_arb();
		wr(OFF_VP0, 8'hd7);
		wr(8'h02, 8'hfd);
		timebaseReq <= 1'b1;
		periphReq <= 7'h02;
		CORE.boundary();
		ent(4'h1, LVL1, 16'hfff8);
		wr(OFF_VP0, 8'hd3);
		CORE.boundary();
		ent(4'h1, LVL2, 16'hfff8);
		pend(1'b0);
		wr(OFF_VP0, 8'hd7);
		wr(8'h02, 8'hfc);
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL1);
		CORE.boundary();
		ent(4'h8, LVL2, 16'hffea);
		timebaseReq <= 1'b0;
		periphReq <= 7'h00;
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL1);
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL0);
		$display("test arb done");
	endtask
	task automatic t_top();
		op(OP_SIM, 8'h00, LVL3);
		CORE.issue(OP_TRAP, 8'h00);
		ent(VEC_TRAP, LVL3, ADDR_TRAP);
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL3);
		timebaseReq <= 1'b1;
		pend(1'b0);
		timebaseReq <= 1'b0;
		wr(OFF_EXT, 8'h11);
		wr(OFF_VP0, 8'hd4);
		tliPin <= 1'b0;
		cyc(2);
		pend(1'b1);
		CORE.boundary();
		ent(VEC_TLI, LVL3, ADDR_SRC0);
		tliPin <= 1'b1;
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL3);
		$display("test top done");
	endtask
	task automatic t_sense();
		extLine <= 4'he;
		cyc(2);
		pend(1'b0);
		wr(OFF_EXT, 8'h19);
		op(OP_RIM, 8'h00, LVL0);
		pend(1'b0);
		extLine <= 4'hf;
		cyc(2);
		pend(1'b1);
		CORE.boundary();
		ent(VEC_EXT0, LVL1, 16'hfff6);
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL0);
		// inverted groups: line 0 falling only, line 2 rising with high level
		op(OP_SIM, 8'h00, LVL3);
		wr(OFF_EXT, 8'h2d);
		pend(1'b0);
		op(OP_RIM, 8'h00, LVL0);
		pend(1'b1);
		CORE.boundary();
		ent(4'h4, LVL3, 16'hfff2);
		// line 2 still requests, but level 3 holds it off
		CORE.boundary();
		pend(1'b0);
		extLine <= 4'ha;
		cyc(2);
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL0);
		pend(1'b1);
		CORE.boundary();
		ent(VEC_EXT0, LVL1, 16'hfff6);
		op(OP_RETURN_FROM_ISR_INSTR, 8'h00, LVL0);
		$display("test sense done");
	endtask
	task automatic wk(input logic [4:0] m, input logic [13:7] p, input logic e);
		@(posedge clock);
		{haltMode, activeHaltMode, spiSlaveMode, artExtClkMode, timebaseReq} <= m;
		periphReq <= p;
		cyc(2);
		@(negedge clock);
		chk("wakeReq", {15'h0, e}, {15'h0, wakeReq});
	endtask
	// mode bits: halt, active halt, spi slave, timer ext clock, time base
	task automatic t_wake();
		wk(5'b10000, 7'h02, 1'b0);
		wk(5'b10001, 7'h00, 1'b1);
		wk(5'b10000, 7'h01, 1'b0);
		wk(5'b10100, 7'h01, 1'b1);
		wk(5'b10010, 7'h40, 1'b1);
		wk(5'b01100, 7'h01, 1'b0);
		wk(5'b01001, 7'h00, 1'b1);
		wk(5'b00000, 7'h00, 1'b0);
		$display("test wake done");
	endtask
	initial begin
		arst_n = 1'b0;
		{regWrEn, regRdEn, timebaseReq, haltMode, activeHaltMode} = 5'h00;
		{spiSlaveMode, artExtClkMode} = 2'b00;
		{regAddr, regWrData} = 16'h0000;
		tliPin = 1'b1;
		extLine = 4'hf;
		periphReq = 7'h00;
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_instr();
		t_entry();
		t_arb();
		t_top();
		t_sense();
		t_wake();
		report_and_stop();
	end
	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#200000;
		err_total++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
